// [core/ccrs_clock_divider.sv]
// Divider producing a clock of ratio peripheral periods
`timescale 1ns/1ps
`include "ccrs_defs.svh"
module ccrs_clock_divider (
  input  wire logic                      ref_clk,     // Core clock
  input  wire logic                      rst,         // Async reset, high
  input  wire logic                      run,         // Core out of reset
  input  wire ccrs_pkg::ccrs_div_cfg_type cfg,        // Divide ratio
  output logic                           div_clock    // Divided clock
);
  logic [`CCRS_DIV_W-1:0] cnt_r;
  logic [`CCRS_DIV_W-1:0] last;

  // Ratio zero behaves as one
  assign last = (cfg.ratio == {`CCRS_DIV_W{1'b0}}) ? {`CCRS_DIV_W{1'b0}} : cfg.ratio - 1'b1;

  // Half period of ratio core cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {`CCRS_DIV_W{1'b0}};
    end else if (!run || cnt_r >= last) begin
      cnt_r <= {`CCRS_DIV_W{1'b0}};
    end else begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Toggle output at each half period
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_clock <= 1'b0;
    end else if (!run) begin
      div_clock <= 1'b0;
    end else if (cnt_r >= last) begin
      div_clock <= ~div_clock;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_div_toggle_edge: assert property (run && cnt_r >= last ##1 run |-> div_clock != $past(div_clock))
    else $error("divided clock missed its toggle");
  a_div_hold_level: assert property (run && cnt_r < last ##1 run |-> $stable(div_clock))
    else $error("divided clock toggled early");
endmodule // ccrs_clock_divider

// [core/ccrs_core_clock_reset_sequencer.sv]
// Core clock derivation and core reset release with AHB-Lite registers
`timescale 1ns/1ps
`include "ccrs_defs.svh"
module ccrs_core_clock_reset_sequencer #(
  parameter int unsigned IN_CYCLES = `CCRS_IN_CYCLES
) (
  input  wire logic        ref_clk,           // Core clock
  input  wire logic        rst,               // Async reset, high
  input  wire logic        input_clock,       // Board input clock pin
  input  wire logic        ext_reset_n,       // Board reset pin, low
  input  wire logic [1:0]  ratio_select_pins, // Ratio strap pins
  input  wire logic        hsel,              // AHB select
  input  wire logic [31:0] haddr,             // AHB address
  input  wire logic [1:0]  htrans,            // AHB transfer type
  input  wire logic        hwrite,            // AHB write
  input  wire logic [2:0]  hsize,             // AHB size
  input  wire logic [31:0] hwdata,            // AHB write data
  input  wire logic        hready,            // AHB bus ready
  output logic             hreadyout,         // AHB slave ready
  output logic             hresp,             // AHB response
  output logic [31:0]      hrdata,            // AHB read data
  output logic             core_reset_out,    // Internal core reset
  output logic             periph_clock,      // Peripheral clock
  output logic             serial_clock,      // Serial port clock
  output logic             spi_clock,         // SPI clock
  output logic [5:0]       core_ratio         // Core to input ratio
);
  localparam logic [`CCRS_CNT_W-1:0] CNT_LAST = `CCRS_CNT_W'(IN_CYCLES - 1);

  // ****************************************
  // Declarations
  // ****************************************
  logic [1:0]                      ext_s;
  logic [2:0]                      in_s;
  logic [1:0]                      pins_s0;
  logic [1:0]                      pins_s1;
  logic                            ext_active;
  logic                            in_fall;
  ccrs_pkg::ccrs_state_type        state_r;
  ccrs_pkg::ccrs_state_type        state_nxt;
  logic [`CCRS_CNT_W-1:0]          cnt_r;
  logic [1:0]                      tail_r;
  logic [1:0]                      latched_pins_r;
  logic [`CCRS_RATIO_W-1:0]        ratio_r;
  logic [`CCRS_RATIO_W-1:0]        ratio_nxt;
  logic                            sw_ratio_r;
  logic                            sw_ratio_nxt;
  ccrs_pkg::ccrs_div_cfg_type      div_cfg_r   [`CCRS_NUM_DIV];
  ccrs_pkg::ccrs_div_cfg_type      div_cfg_nxt [`CCRS_NUM_DIV];
  logic [`CCRS_NUM_DIV-1:0]        div_clk;
  ccrs_pkg::ccrs_aphase_type       ap_r;
  logic                            wr_fire;
  logic                            run;

  // Ratio decode of the strap pins
  function automatic logic [`CCRS_RATIO_W-1:0] pin_ratio(input logic [1:0] p);
    case (p)
      2'h0:    pin_ratio = `CCRS_RATIO_CFG00;
      2'h1:    pin_ratio = `CCRS_RATIO_CFG01;
      2'h2:    pin_ratio = `CCRS_RATIO_CFG10;
      default: pin_ratio = `CCRS_RATIO_CFG11;
    endcase
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // Two flops on every pin, third flop for input clock edges
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_s   <= 2'h0;
      in_s    <= 3'h0;
      pins_s0 <= 2'h0;
      pins_s1 <= 2'h0;
    end else begin
      ext_s   <= {ext_s[0], ext_reset_n};
      in_s    <= {in_s[1:0], input_clock};
      pins_s0 <= ratio_select_pins;
      pins_s1 <= pins_s0;
    end
  end

  assign ext_active = ~ext_s[1];
  assign in_fall    = in_s[2] & ~in_s[1];

  // ****************************************
  // Reset sequencer
  // ****************************************
  // Next state of the release sequence
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ccrs_pkg::ST_HOLD: begin
        if (!ext_active) state_nxt = ccrs_pkg::ST_COUNT;
      end
      ccrs_pkg::ST_COUNT: begin
        if (ext_active) state_nxt = ccrs_pkg::ST_HOLD;
        else if (in_fall && cnt_r == CNT_LAST) state_nxt = ccrs_pkg::ST_TAIL;
      end
      ccrs_pkg::ST_TAIL: begin
        if (ext_active) state_nxt = ccrs_pkg::ST_HOLD;
        else if (tail_r == `CCRS_TAIL_LAST) state_nxt = ccrs_pkg::ST_RUN;
      end
      ccrs_pkg::ST_RUN: begin
        if (ext_active) state_nxt = ccrs_pkg::ST_HOLD;
      end
      default: state_nxt = ccrs_pkg::ST_HOLD;
    endcase
  end

  // State and core reset register
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r        <= ccrs_pkg::ST_HOLD;
      core_reset_out <= 1'b1;
    end else begin
      state_r        <= state_nxt;
      core_reset_out <= (state_nxt != ccrs_pkg::ST_RUN);
    end
  end

  // Input clock falling edges since release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= {`CCRS_CNT_W{1'b0}};
    end else if (state_r == ccrs_pkg::ST_HOLD || ext_active) begin
      cnt_r <= {`CCRS_CNT_W{1'b0}};
    end else if (state_r == ccrs_pkg::ST_COUNT && in_fall) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // Core clock cycles after the input count
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tail_r <= 2'h0;
    end else if (state_r == ccrs_pkg::ST_TAIL) begin
      tail_r <= tail_r + 1'b1;
    end else begin
      tail_r <= 2'h0;
    end
  end

  // Strap pins tracked in reset, frozen at release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latched_pins_r <= 2'h0;
    end else if (ext_active) begin
      latched_pins_r <= pins_s1;
    end
  end

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_fire   = ap_r.valid & ap_r.write;

  // Address phase capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ap_r <= '0;
    end else if (hready) begin
      ap_r.valid <= hsel & htrans[1];
      ap_r.write <= hwrite;
      ap_r.addr  <= haddr[`CCRS_ADDR_W-1:0];
    end
  end

  // Register next values, writes in data phase
  always_comb begin
    ratio_nxt      = ratio_r;
    sw_ratio_nxt   = sw_ratio_r;
    div_cfg_nxt[0] = div_cfg_r[0];
    div_cfg_nxt[1] = div_cfg_r[1];
    if (ext_active) begin
      ratio_nxt    = pin_ratio(pins_s1);
      sw_ratio_nxt = 1'b0;
    end else if (wr_fire && ap_r.addr == `CCRS_OFF_PWR_CTL) begin
      ratio_nxt    = hwdata[`CCRS_RATIO_W-1:0];
      sw_ratio_nxt = 1'b1;
    end
    if (wr_fire && ap_r.addr == `CCRS_OFF_SER_DIV) div_cfg_nxt[0].ratio = hwdata[`CCRS_DIV_W-1:0];
    if (wr_fire && ap_r.addr == `CCRS_OFF_SPI_RATE) div_cfg_nxt[1].ratio = hwdata[`CCRS_DIV_W-1:0];
  end

  // Control registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ratio_r      <= `CCRS_RATIO_CFG00;
      sw_ratio_r   <= 1'b0;
      div_cfg_r[0] <= `CCRS_DIV_RST;
      div_cfg_r[1] <= `CCRS_DIV_RST;
    end else begin
      ratio_r      <= ratio_nxt;
      sw_ratio_r   <= sw_ratio_nxt;
      div_cfg_r[0] <= div_cfg_nxt[0];
      div_cfg_r[1] <= div_cfg_nxt[1];
    end
  end

  // Read data taken in the address phase, forwarded from pending writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      hrdata <= 32'h0;
      case (haddr[`CCRS_ADDR_W-1:0])
        `CCRS_OFF_PWR_CTL: begin
          hrdata[`CCRS_RATIO_W-1:0] <= ratio_nxt;
          hrdata[`CCRS_PM_SW_BIT]   <= sw_ratio_nxt;
        end
        `CCRS_OFF_SER_DIV:  hrdata[`CCRS_DIV_W-1:0] <= div_cfg_nxt[0].ratio;
        `CCRS_OFF_SPI_RATE: hrdata[`CCRS_DIV_W-1:0] <= div_cfg_nxt[1].ratio;
        `CCRS_OFF_STATUS: begin
          hrdata[`CCRS_ST_RST_BIT]                        <= core_reset_out;
          hrdata[`CCRS_ST_EXT_BIT]                        <= ext_active;
          hrdata[`CCRS_ST_PINS_LSB+1:`CCRS_ST_PINS_LSB]   <= latched_pins_r;
          hrdata[`CCRS_ST_CNT_LSB+`CCRS_CNT_W-1:`CCRS_ST_CNT_LSB] <= cnt_r;
        end
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Derived clocks
  // ****************************************
  assign run        = ~core_reset_out;
  assign core_ratio = ratio_r;

  // Peripheral clock toggles every core cycle
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      periph_clock <= 1'b0;
    end else if (!run) begin
      periph_clock <= 1'b0;
    end else begin
      periph_clock <= ~periph_clock;
    end
  end

  // Serial port and SPI dividers
  genvar gi;
  generate
    for (gi = 0; gi < `CCRS_NUM_DIV; gi++) begin : g_div
      ccrs_clock_divider u_div (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .run       (run),
        .cfg       (div_cfg_r[gi]),
        .div_clock (div_clk[gi])
      );
    end
  endgenerate

  assign serial_clock = div_clk[0];
  assign spi_clock    = div_clk[1];

  // ****************************************
  // Assertions
  // ****************************************
  logic [`CCRS_CNT_W-1:0] fall_total_r;
  // Input falls seen since the last reset release
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fall_total_r <= {`CCRS_CNT_W{1'b0}};
    end else if (ext_active) begin
      fall_total_r <= {`CCRS_CNT_W{1'b0}};
    end else if (in_fall && core_reset_out) begin
      fall_total_r <= fall_total_r + 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_count_done;
    state_r == ccrs_pkg::ST_COUNT && !ext_active && in_fall && cnt_r == CNT_LAST;
  endsequence
  a_pclk_twice_core: assert property (run ##1 run |-> periph_clock != $past(periph_clock))
    else $error("peripheral clock not at half core rate");
  a_core_tail_hold: assert property (s_count_done |=> core_reset_out [*2])
    else $error("core reset released before tail");
  a_core_release: assert property (s_count_done ##1 (!ext_active) [*2] |-> ##1 !core_reset_out)
    else $error("core reset not released after tail");
  a_core_hold_count: assert property (cnt_r < CNT_LAST |-> core_reset_out)
    else $error("core reset released during count");
  a_release_bound: assert property ($fell(core_reset_out) |-> fall_total_r >= CNT_LAST && fall_total_r <= CNT_LAST + 2'h2)
    else $error("core reset delay out of bounds");
  a_pin_ratio: assert property (ext_active |=> ratio_r == pin_ratio($past(pins_s1)))
    else $error("ratio not taken from pins in reset");
  a_sw_ratio: assert property (wr_fire && ap_r.addr == `CCRS_OFF_PWR_CTL && !ext_active |=> core_ratio == $past(hwdata[`CCRS_RATIO_W-1:0]))
    else $error("software ratio write lost");
  a_pin_latch: assert property ($fell(ext_active) |-> latched_pins_r == $past(pins_s1))
    else $error("strap pins not latched at release");
  a_pin_frozen: assert property (!ext_active ##1 !ext_active |-> $stable(latched_pins_r))
    else $error("latched pins changed after release");
endmodule // ccrs_core_clock_reset_sequencer

// [core/ccrs_defs.svh]
// Constants of the core clock and reset sequencer
// Behaviour
// - Peripheral clock period is twice core period
// - Serial clock period is peripheral times ratio
// - SPI clock period is peripheral times ratio
// - Pin ratios include 6, 16 and 32
// - Software writes further ratios into control
// - Core reset held 4096 input plus 2
// - Missed setup may add one input cycle
// - Ratio taken from pins during reset
`ifndef CCRS_DEFS_SVH
`define CCRS_DEFS_SVH

// ****************************************
// Register map
// ****************************************
`define CCRS_ADDR_W        8
`define CCRS_OFF_PWR_CTL   8'h00
`define CCRS_OFF_SER_DIV   8'h04
`define CCRS_OFF_SPI_RATE  8'h08
`define CCRS_OFF_STATUS    8'h0C

// ****************************************
// Fields and reset values
// ****************************************
`define CCRS_RATIO_W       6
`define CCRS_RATIO_CFG00   6'h06
`define CCRS_RATIO_CFG01   6'h20
`define CCRS_RATIO_CFG10   6'h10
`define CCRS_RATIO_CFG11   6'h06
`define CCRS_PM_SW_BIT     8
`define CCRS_DIV_W         16
`define CCRS_DIV_RST       16'h0004
`define CCRS_ST_RST_BIT    0
`define CCRS_ST_EXT_BIT    1
`define CCRS_ST_PINS_LSB   2
`define CCRS_ST_CNT_LSB    16

// ****************************************
// Timing counts
// ****************************************
`define CCRS_IN_CYCLES     4096
`define CCRS_CNT_W         14
`define CCRS_TAIL_LAST     2'h1
`define CCRS_NUM_DIV       2

`endif

// [core/ccrs_pkg.sv]
// Types of the core clock and reset sequencer
`include "ccrs_defs.svh"
package ccrs_pkg;
  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_HOLD  = 2'h0,
    ST_COUNT = 2'h1,
    ST_TAIL  = 2'h2,
    ST_RUN   = 2'h3
  } ccrs_state_type;

  // Settings of one clock divider
  typedef struct packed {
    logic [`CCRS_DIV_W-1:0] ratio;
  } ccrs_div_cfg_type;

  // Captured AHB address phase
  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic [`CCRS_ADDR_W-1:0] addr;
  } ccrs_aphase_type;
endpackage

// [verification/ccrs_board_model.sv]
// Board reset source and free running input clock oscillator
`timescale 1ns/1ps
module ccrs_board_model #(
  parameter real         CLK_HALF_NS  = 50.0,
  parameter int unsigned PLL_SETUP_NS = 20000
) (
  output logic       input_clock,       // Board input clock
  output logic       ext_reset_n,       // Board reset, low
  output logic [1:0] ratio_select_pins  // Ratio strap pins
);
  // ****
  // Oscillator, stable from time zero
  // ****
  initial begin
    input_clock = 1'b0;
    ext_reset_n = 1'b0;
    ratio_select_pins = 2'h0;
    #7;
    forever #(CLK_HALF_NS) input_clock = ~input_clock;
  end

  // Drive reset low with straps on them
  task automatic hold_low(input logic [1:0] pins);
    ext_reset_n = 1'b0;
    ratio_select_pins = pins;
  endtask

  // Full reset pulse, release just after a rising edge
  task automatic board_reset(input logic [1:0] pins);
    hold_low(pins);
    repeat (8) @(posedge input_clock);
    #(PLL_SETUP_NS);
    @(posedge input_clock);
    ext_reset_n = 1'b1;
  endtask

  // Move the straps after release
  task automatic set_pins(input logic [1:0] pins);
    ratio_select_pins = pins;
  endtask
endmodule // ccrs_board_model

// [verification/tb_core_clock_reset_sequencer.sv]
// Testbench of the core clock and reset sequencer
`timescale 1ns/1ps
`include "ccrs_defs.svh"
module tb_core_clock_reset_sequencer;
  localparam int IN_CYC = 16;
  localparam int IN_REF = 4;
  localparam int LIMIT  = 20000;
  logic        ref_clk, rst, input_clock, ext_reset_n, hsel, hwrite, hready;
  logic        hreadyout, hresp, core_reset_out, periph_clock, serial_clock, spi_clock;
  logic [1:0]  ratio_select_pins, htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [5:0]  core_ratio;
  int          n_mismatch, total_checks, cyc;

  // ****
  // Clock, reset, instances
  // ****
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  assign hready = hreadyout;

  ccrs_core_clock_reset_sequencer #(.IN_CYCLES(IN_CYC)) ccrs_core_clock_reset_sequencer_inst (
    .ref_clk(ref_clk), .rst(rst), .input_clock(input_clock), .ext_reset_n(ext_reset_n),
    .ratio_select_pins(ratio_select_pins), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .core_reset_out(core_reset_out), .periph_clock(periph_clock),
    .serial_clock(serial_clock), .spi_clock(spi_clock), .core_ratio(core_ratio));

  ccrs_board_model ccrs_board_model_inst (
    .input_clock(input_clock), .ext_reset_n(ext_reset_n), .ratio_select_pins(ratio_select_pins));

  // ****
  // Report and compare
  // ****
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic chk_span(input string nm, input int lo, input int hi, input int g);
    total_checks++;
    if (g < lo || g > hi) begin
      n_mismatch++;
      $display("BAD %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end

  // ****
  // AHB-Lite master
  // ****
  task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk_val("hresp", 32'h0, {31'h0, hresp});
  endtask

  function automatic logic pick(input int s);
    return (s == 0) ? periph_clock : (s == 1) ? serial_clock : spi_clock;
  endfunction

  // Ref cycles between two rising edges of a derived clock
  task automatic t_period(input string nm, input int sel, input int e);
    int st, cnt;
    logic p, c;
    st = 0;
    cnt = 0;
    #1;
    p = pick(sel);
    for (int k = 0; k < 200 && st < 2; k++) begin
      @(posedge ref_clk);
      #1;
      c = pick(sel);
      if (st > 0) cnt++;
      if (c === 1'b1 && p === 1'b0) st++;
      p = c;
    end
    chk_val(nm, e, cnt);
  endtask

  // ****
  // Scenarios
  // ****
  task automatic t_release(input logic [1:0] pins, input logic [5:0] e);
    int n;
    n = 0;
    ccrs_board_model_inst.board_reset(pins);
    chk_val("strap_ratio", e, core_ratio);
    chk_val("core_reset_held", 1, core_reset_out);
    while (core_reset_out !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk_span("core_reset_delay", (IN_CYC - 1) * IN_REF, (IN_CYC + 1) * IN_REF + 8, n);
  endtask

  task automatic t_latch;
    ccrs_board_model_inst.set_pins(2'h1);
    repeat (10) @(posedge ref_clk);
    chk_val("ratio_after_release", `CCRS_RATIO_CFG10, core_ratio);
    ahb_xfer(1'b0, `CCRS_OFF_STATUS, 32'h0);
    chk_val("latched_pins", 2'h2, rd[3:2]);
    chk_val("status_core_reset", 0, rd[0]);
  endtask

  task automatic t_clocks;
    t_period("periph_period", 0, 2);
    ahb_xfer(1'b0, `CCRS_OFF_SER_DIV, 32'h0);
    chk_val("serial_div_reset", `CCRS_DIV_RST, rd);
    t_period("serial_period_rst", 1, 8);
    ahb_xfer(1'b1, `CCRS_OFF_SER_DIV, 32'h3);
    t_period("serial_period", 1, 6);
    ahb_xfer(1'b0, `CCRS_OFF_SPI_RATE, 32'h0);
    chk_val("spi_rate_reset", `CCRS_DIV_RST, rd);
    ahb_xfer(1'b1, `CCRS_OFF_SPI_RATE, 32'h5);
    t_period("spi_period", 2, 10);
  endtask

  task automatic t_pwr_ctl;
    ahb_xfer(1'b1, `CCRS_OFF_PWR_CTL, 32'h0A);
    ahb_xfer(1'b0, `CCRS_OFF_PWR_CTL, 32'h0);
    chk_val("pwr_ctl_ratio", 6'h0A, rd[5:0]);
    chk_val("pwr_ctl_sw_flag", 1, rd[8]);
    chk_val("core_ratio_sw", 6'h0A, core_ratio);
    ahb_xfer(1'b0, 8'h10, 32'h0);
    chk_val("unmapped_read", 0, rd);
  endtask

  task automatic t_held;
    ccrs_board_model_inst.hold_low(2'h2);
    repeat (6) @(posedge ref_clk);
    ahb_xfer(1'b1, `CCRS_OFF_PWR_CTL, 32'h14);
    repeat (4) @(posedge ref_clk);
    #1;
    chk_val("ratio_in_reset", `CCRS_RATIO_CFG10, core_ratio);
    chk_val("core_reset_in_reset", 1, core_reset_out);
    chk_val("periph_in_reset", 0, periph_clock);
    chk_val("serial_in_reset", 0, serial_clock);
    chk_val("spi_in_reset", 0, spi_clock);
    t_release(2'h1, `CCRS_RATIO_CFG01);
  endtask

  // Main sequence
  initial begin
    n_mismatch = 0;
    total_checks = 0;
    cyc = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd = 32'h0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_release(2'h0, `CCRS_RATIO_CFG00);
    t_release(2'h1, `CCRS_RATIO_CFG01);
    t_release(2'h3, `CCRS_RATIO_CFG11);
    t_release(2'h2, `CCRS_RATIO_CFG10);
    t_latch();
    t_clocks();
    t_pwr_ctl();
    t_held();
    end_sim();
  end
endmodule // tb_core_clock_reset_sequencer
